// ### hw/sesa_pkg.sv
`default_nettype none

package sesa_pkg;

   // ------------------------------------------------------------
   // Address byte layout and memory geometry
   // ------------------------------------------------------------
   localparam logic [3:0] DEV_CODE    = 4'hA;
   localparam int         DEV_CODE_LO = 4;
   localparam int         SEL_LO      = 1;
   localparam int         RW_BIT      = 0;
   localparam int         PAGE_AW     = 5;
   localparam int         PAGE_BYTES  = 32;
   localparam int         MEM_AW      = 11;

   // ------------------------------------------------------------
   // Bit counter marks within one nine-clock byte slot
   // ------------------------------------------------------------
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_END = 4'h9;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic       RST_LINE = 1'b1;
   localparam logic [7:0] RST_BYTE = 8'h00;

   // ------------------------------------------------------------
   // Self-timed write cycle
   // ------------------------------------------------------------
   localparam int T_WR_NS   = 5000000;
   localparam int CLK_NS    = 10;
   localparam int WR_CYCLES = T_WR_NS / CLK_NS;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DEV,
      ST_WORD,
      ST_WDATA,
      ST_RDATA
   } sesa_state_t;

endpackage

`default_nettype wire

// ### hw/sesa_top.sv
`timescale 1ns/1ps
`default_nettype none

module sesa_top #(
   parameter int MEM_AW    = sesa_pkg::MEM_AW,
   parameter int WR_CYCLES = sesa_pkg::WR_CYCLES
) (
   // Clocks and reset
   input  wire logic ref_clk,
   input  wire logic link_clk,
   input  wire logic sys_rst,
   // Two-wire bus pins
   input  wire logic scl_i,
   input  wire logic sda_i,
   output var  logic sda_o,
   output var  logic sda_oe,
   // Status
   output var  logic write_busy
);

   localparam int CW = $clog2(WR_CYCLES + 1);
   localparam int BW = MEM_AW - sesa_pkg::PAGE_AW;

   if (MEM_AW <= sesa_pkg::PAGE_AW || MEM_AW > 11 || WR_CYCLES < 1) begin : g_bad_param
      $error("sesa_top: MEM_AW must lie in 6..11 and WR_CYCLES be at least 1.");
   end

   // ------------------------------------------------------------
   // Link-side and ref-side state
   // ------------------------------------------------------------
   typedef struct packed {
      logic                        scl_m;
      logic                        scl_s;
      logic                        scl_p;
      logic                        sda_m;
      logic                        sda_s;
      logic                        sda_p;
      logic                        bsy_m;
      logic                        bsy_s;
      sesa_pkg::sesa_state_t       st;
      logic [3:0]                  bitcnt;
      logic [7:0]                  rx;
      logic [7:0]                  tx;
      logic                        rw;
      logic [2:0]                  sel;
      logic                        mack;
      logic [MEM_AW-1:0]           addr;
      logic                        wdirty;
      logic [sesa_pkg::PAGE_BYTES-1:0] mask;
      logic                        commit;
      logic [sesa_pkg::PAGE_AW-1:0] cidx;
      logic [BW-1:0]               cbase;
      logic                        req_t;
      logic                        wait_l;
      logic                        seen;
      logic                        sda_oe;
      logic                        sda_o;
   } sesa_link_t;

   typedef struct packed {
      logic          req_m;
      logic          req_s;
      logic          req_p;
      logic          busy;
      logic [CW-1:0] cnt;
   } sesa_ref_t;

   sesa_link_t ln_q;
   sesa_link_t ln_d;
   sesa_ref_t  rf_q;
   sesa_ref_t  rf_d;

   logic [7:0] mem  [2**MEM_AW];
   logic [7:0] pbuf [sesa_pkg::PAGE_BYTES];
   logic [7:0] mem_rd;
   logic       rise;
   logic       fall;
   logic       start;
   logic       stop;
   logic       busy;
   logic       load;
   logic       we_pb;
   logic       mem_we;

   assign mem_rd = mem[ln_q.addr];
   assign rise   = ln_q.scl_s & ~ln_q.scl_p;
   assign fall   = ~ln_q.scl_s & ln_q.scl_p;
   assign start  = ln_q.scl_s & ln_q.scl_p & ln_q.sda_p & ~ln_q.sda_s;
   assign stop   = ln_q.scl_s & ln_q.scl_p & ~ln_q.sda_p & ln_q.sda_s;
   // Busy covers the gap until the timer's level has crossed back, so a poll that
   // arrives right after stop is never acknowledged too early.
   assign busy   = ln_q.wait_l | ln_q.commit;

   // ------------------------------------------------------------
   // Protocol engine
   // ------------------------------------------------------------
   always_comb begin
      ln_d        = ln_q;
      load        = 1'b0;
      we_pb       = 1'b0;
      mem_we      = 1'b0;
      ln_d.scl_m  = scl_i;
      ln_d.scl_s  = ln_q.scl_m;
      ln_d.scl_p  = ln_q.scl_s;
      ln_d.sda_m  = sda_i;
      ln_d.sda_s  = ln_q.sda_m;
      ln_d.sda_p  = ln_q.sda_s;
      ln_d.bsy_m  = rf_q.busy;
      ln_d.bsy_s  = ln_q.bsy_m;
      ln_d.sda_o  = 1'b0;
      if (ln_q.commit) begin
         mem_we    = ln_q.mask[ln_q.cidx];
         ln_d.cidx = ln_q.cidx + 1'b1;
         if (ln_q.cidx == 5'h1F) begin
            ln_d.commit = 1'b0;
            ln_d.mask   = '0;
         end
      end
      if (ln_q.wait_l) begin
         if (ln_q.bsy_s) begin
            ln_d.seen = 1'b1;
         end else if (ln_q.seen && !ln_q.commit) begin
            ln_d.wait_l = 1'b0;
            ln_d.seen   = 1'b0;
         end
      end
      if (start) begin
         ln_d.st     = sesa_pkg::ST_DEV;
         ln_d.bitcnt = '0;
         ln_d.sda_oe = 1'b0;
      end else if (stop) begin
         ln_d.st     = sesa_pkg::ST_IDLE;
         ln_d.sda_oe = 1'b0;
         if (ln_q.wdirty) begin
            ln_d.wdirty = 1'b0;
            ln_d.commit = 1'b1;
            ln_d.cidx   = '0;
            ln_d.req_t  = ~ln_q.req_t;
            ln_d.wait_l = 1'b1;
            ln_d.seen   = 1'b0;
         end
      end else if (ln_q.st != sesa_pkg::ST_IDLE) begin
         if (rise) begin
            if (ln_q.bitcnt < sesa_pkg::BIT_ACK) begin
               ln_d.rx     = {ln_q.rx[6:0], ln_q.sda_s};
               ln_d.bitcnt = ln_q.bitcnt + 1'b1;
            end else if (ln_q.bitcnt == sesa_pkg::BIT_ACK) begin
               ln_d.mack   = ~ln_q.sda_s;
               ln_d.bitcnt = sesa_pkg::BIT_END;
            end
         end else if (fall) begin
            if (ln_q.bitcnt == sesa_pkg::BIT_ACK) begin
               case (ln_q.st)
                  sesa_pkg::ST_DEV: begin
                     if (ln_q.rx[7:sesa_pkg::DEV_CODE_LO] == sesa_pkg::DEV_CODE && !busy) begin
                        ln_d.sda_oe = 1'b1;
                        ln_d.rw     = ln_q.rx[sesa_pkg::RW_BIT];
                        ln_d.sel    = ln_q.rx[sesa_pkg::SEL_LO +: 3];
                     end else begin
                        ln_d.st = sesa_pkg::ST_IDLE;
                     end
                  end
                  sesa_pkg::ST_WORD: begin
                     ln_d.addr   = MEM_AW'({ln_q.sel, ln_q.rx});
                     ln_d.cbase  = BW'({ln_q.sel, ln_q.rx} >> sesa_pkg::PAGE_AW);
                     ln_d.sda_oe = 1'b1;
                  end
                  sesa_pkg::ST_WDATA: begin
                     we_pb                 = 1'b1;
                     ln_d.mask[ln_q.addr[4:0]] = 1'b1;
                     ln_d.wdirty           = 1'b1;
                     ln_d.addr[4:0]        = ln_q.addr[4:0] + 1'b1;
                     ln_d.sda_oe           = 1'b1;
                  end
                  default: begin
                     ln_d.sda_oe = 1'b0;
                  end
               endcase
            end else if (ln_q.bitcnt == sesa_pkg::BIT_END) begin
               ln_d.bitcnt = '0;
               ln_d.sda_oe = 1'b0;
               case (ln_q.st)
                  sesa_pkg::ST_DEV: begin
                     if (ln_q.rw) begin
                        load = 1'b1;
                     end else begin
                        ln_d.st = sesa_pkg::ST_WORD;
                     end
                  end
                  sesa_pkg::ST_WORD: begin
                     ln_d.st = sesa_pkg::ST_WDATA;
                  end
                  sesa_pkg::ST_RDATA: begin
                     if (ln_q.mack) begin
                        load = 1'b1;
                     end else begin
                        ln_d.st = sesa_pkg::ST_IDLE;
                     end
                  end
                  default: begin
                     ln_d.st = ln_q.st;
                  end
               endcase
            end else if (ln_q.st == sesa_pkg::ST_RDATA && ln_q.bitcnt != '0) begin
               ln_d.tx     = {ln_q.tx[6:0], 1'b0};
               ln_d.sda_oe = ~ln_q.tx[6];
            end
         end
      end
      if (load) begin
         ln_d.st     = sesa_pkg::ST_RDATA;
         ln_d.tx     = mem_rd;
         ln_d.sda_oe = ~mem_rd[7];
         ln_d.addr   = ln_q.addr + 1'b1;
      end
   end

   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ln_q       <= '0;
         ln_q.scl_m <= sesa_pkg::RST_LINE;
         ln_q.scl_s <= sesa_pkg::RST_LINE;
         ln_q.scl_p <= sesa_pkg::RST_LINE;
         ln_q.sda_m <= sesa_pkg::RST_LINE;
         ln_q.sda_s <= sesa_pkg::RST_LINE;
         ln_q.sda_p <= sesa_pkg::RST_LINE;
         ln_q.st    <= sesa_pkg::ST_IDLE;
      end else begin
         ln_q <= ln_d;
      end
   end

   // Arrays carry no reset: contents are undefined until written.
   always_ff @(posedge link_clk) begin
      if (we_pb) begin
         pbuf[ln_q.addr[4:0]] <= ln_q.rx;
      end
      if (mem_we) begin
         mem[{ln_q.cbase, ln_q.cidx}] <= pbuf[ln_q.cidx];
      end
   end

   // ------------------------------------------------------------
   // Write cycle timer
   // ------------------------------------------------------------
   always_comb begin
      rf_d       = rf_q;
      rf_d.req_m = ln_q.req_t;
      rf_d.req_s = rf_q.req_m;
      rf_d.req_p = rf_q.req_s;
      if (rf_q.req_s ^ rf_q.req_p) begin
         rf_d.busy = 1'b1;
         rf_d.cnt  = CW'(WR_CYCLES - 1);
      end else if (rf_q.busy) begin
         if (rf_q.cnt == '0) begin
            rf_d.busy = 1'b0;
         end else begin
            rf_d.cnt = rf_q.cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rf_q <= '0;
      end else begin
         rf_q <= rf_d;
      end
   end

   assign sda_o      = ln_q.sda_o;
   assign sda_oe     = ln_q.sda_oe;
   assign write_busy = rf_q.busy;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_sda_open_drain: assert property (@(posedge link_clk) disable iff (sys_rst)
      !ln_q.sda_o) else $error("SDA driven high");
   a_dev_mismatch: assert property (@(posedge link_clk) disable iff (sys_rst)
      (fall && !start && !stop && ln_q.st == sesa_pkg::ST_DEV && ln_q.bitcnt == sesa_pkg::BIT_ACK
       && ln_q.rx[7:4] != sesa_pkg::DEV_CODE) |=> !ln_q.sda_oe && ln_q.st == sesa_pkg::ST_IDLE)
      else $error("Foreign address acknowledged");
   a_dev_ack: assert property (@(posedge link_clk) disable iff (sys_rst)
      (fall && !start && !stop && ln_q.st == sesa_pkg::ST_DEV && ln_q.bitcnt == sesa_pkg::BIT_ACK
       && ln_q.rx[7:4] == sesa_pkg::DEV_CODE && !busy) |=> ln_q.sda_oe && ln_q.rw == $past(ln_q.rx[0]))
      else $error("Matching address not acknowledged");
   a_busy_nack: assert property (@(posedge link_clk) disable iff (sys_rst)
      (fall && ln_q.st == sesa_pkg::ST_DEV && ln_q.bitcnt == sesa_pkg::BIT_ACK && busy) |=> !ln_q.sda_oe)
      else $error("Acknowledged while programming");
   a_word_addr: assert property (@(posedge link_clk) disable iff (sys_rst)
      (fall && !start && !stop && ln_q.st == sesa_pkg::ST_WORD && ln_q.bitcnt == sesa_pkg::BIT_ACK)
      |=> ln_q.addr == MEM_AW'({$past(ln_q.sel), $past(ln_q.rx)}))
      else $error("Word address not loaded");
   a_page_wrap: assert property (@(posedge link_clk) disable iff (sys_rst)
      (fall && !start && !stop && ln_q.st == sesa_pkg::ST_WDATA && ln_q.bitcnt == sesa_pkg::BIT_ACK)
      |=> ln_q.addr[MEM_AW-1:5] == $past(ln_q.addr[MEM_AW-1:5])
          && ln_q.addr[4:0] == 5'($past(ln_q.addr[4:0]) + 5'h01))
      else $error("Page offset step wrong");
   a_read_step: assert property (@(posedge link_clk) disable iff (sys_rst)
      load |=> ln_q.addr == MEM_AW'($past(ln_q.addr) + 1'b1) && ln_q.sda_oe == ~$past(mem_rd[7]))
      else $error("Read counter or first bit wrong");
   a_commit_len: assert property (@(posedge link_clk) disable iff (sys_rst)
      $rose(ln_q.commit) |-> ln_q.commit [*8] ##24 ln_q.commit ##1 !ln_q.commit)
      else $error("Commit length wrong");
   a_commit_start: assert property (@(posedge link_clk) disable iff (sys_rst)
      (stop && ln_q.wdirty) |=> ln_q.commit && ln_q.wait_l) else $error("Stop did not start programming");
   a_wr_timer: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $rose(rf_q.busy) |-> rf_q.busy [*8]) else $error("Write cycle ended early");

   c_byte_write: cover property (@(posedge link_clk) disable iff (sys_rst) $rose(ln_q.commit));
   c_seq_read: cover property (@(posedge link_clk) disable iff (sys_rst) load && ln_q.st == sesa_pkg::ST_RDATA);
   c_poll_nack: cover property (@(posedge link_clk) disable iff (sys_rst)
      fall && ln_q.st == sesa_pkg::ST_DEV && ln_q.bitcnt == sesa_pkg::BIT_ACK && busy);

endmodule

`default_nettype wire

// ### tb/sesa_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Two-wire bus master
// ------------------------------------------------------------
module sesa_master_model #(
   parameter int Q_NS = 80
) (
   // Bus pins
   output var  logic scl,
   output var  logic sda_drv,
   input  wire logic sda
);
   initial begin
      scl     = 1'b1;
      sda_drv = 1'b1;
   end

   // Serves as first and as repeated start. SCL rises only three steps after its fall,
   // so an acknowledge that the device lets go late never looks like a stop.
   task automatic start_cond();
      #(Q_NS) sda_drv = 1'b1;
      #(2*Q_NS) scl = 1'b1;
      #(2*Q_NS) sda_drv = 1'b0;
      #(2*Q_NS) scl = 1'b0;
   endtask

   task automatic stop_cond();
      #(Q_NS) sda_drv = 1'b0;
      #(2*Q_NS) scl = 1'b1;
      #(2*Q_NS) sda_drv = 1'b1;
      #(2*Q_NS);
   endtask

   task automatic bit_xfer(input logic b, output logic r);
      #(Q_NS) sda_drv = b;
      #(2*Q_NS) scl = 1'b1;
      #(Q_NS) r = sda;
      #(Q_NS) scl = 1'b0;
   endtask

   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(d[i], r);
      end
      bit_xfer(1'b1, r);
      ack = ~r;
   endtask

   task automatic recv_byte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(1'b1, r);
         d[i] = r;
      end
      bit_xfer(~more, r);
   endtask
endmodule

`default_nettype wire

// ### tb/sesa_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module sesa_tb_top;
   localparam int WR_CYC = 1000;
   localparam int LIMIT  = 90000;

   typedef struct packed {
      logic [2:0] sel;
      logic [7:0] word;
      logic [7:0] data;
   } sesa_row_t;

   logic       ref_clk;
   logic       link_clk;
   logic       sys_rst;
   logic       scl;
   logic       sda_drv;
   logic       sda_o;
   logic       sda_oe;
   logic       write_busy;
   wire        sda;
   int         bad_count = 0;
   int         tests_run = 0;
   int         cycles    = 0;
   logic       ack;
   logic [7:0] rd;
   sesa_row_t  rows [4];

   // Pull-up on the data wire: low whenever either party pulls it.
   assign sda = sda_drv & ~(sda_oe & ~sda_o);

   sesa_top #(
      .MEM_AW    (sesa_pkg::MEM_AW),
      .WR_CYCLES (WR_CYC)
   ) sesa_top_i (
      .ref_clk    (ref_clk),
      .link_clk   (link_clk),
      .sys_rst    (sys_rst),
      .scl_i      (scl),
      .sda_i      (sda),
      .sda_o      (sda_o),
      .sda_oe     (sda_oe),
      .write_busy (write_busy)
   );

   sesa_master_model sesa_master_model_i (
      .scl     (scl),
      .sda_drv (sda_drv),
      .sda     (sda)
   );

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   initial begin
      link_clk = 1'b0;
      #3.7;
      forever #16 link_clk = ~link_clk;
   end

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         bad_count = bad_count + 1;
         end_of_test();
      end
   end

   // ------------------------------------------------------------
   // Checking and bus helpers
   // ------------------------------------------------------------
   task automatic end_of_test();
      if (bad_count == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected byte at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected bit at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   // A page write of 33 bytes from offset 30 leaves the last byte at offset 30.
   function automatic logic [7:0] page_exp(input int off);
      int k;
      k = (off == 30) ? 32 : (off == 31) ? 1 : off + 2;
      return 8'h40 + k[7:0];
   endfunction

   task automatic dev_addr(input logic [2:0] sel, input logic rnw, output logic a);
      sesa_master_model_i.start_cond();
      sesa_master_model_i.send_byte({sesa_pkg::DEV_CODE, sel, rnw}, a);
   endtask

   task automatic set_pointer(input logic [2:0] sel, input logic [7:0] word);
      logic a;
      dev_addr(sel, 1'b0, a);
      check_bit(a, 1'b1);
      sesa_master_model_i.send_byte(word, a);
      check_bit(a, 1'b1);
   endtask

   // The first poll lands well inside the write cycle, so it must be refused.
   task automatic wait_ready();
      int   n;
      logic a;
      n = 0;
      dev_addr(3'h0, 1'b0, a);
      check_bit(a, 1'b0);
      check_bit(write_busy, 1'b1);
      while (a !== 1'b1 && n < 20) begin
         sesa_master_model_i.stop_cond();
         dev_addr(3'h0, 1'b0, a);
         n++;
      end
      check_bit(a, 1'b1);
      check_bit(write_busy, 1'b0);
      sesa_master_model_i.stop_cond();
   endtask

   task automatic read_at(input logic [2:0] sel, input logic [7:0] word);
      logic a;
      set_pointer(sel, word);
      dev_addr(sel, 1'b1, a);
      check_bit(a, 1'b1);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      rows[0] = '{3'h7, 8'hFF, 8'h5A};
      rows[1] = '{3'h0, 8'h00, 8'hC3};
      rows[2] = '{3'h3, 8'h41, 8'h96};
      rows[3] = '{3'h5, 8'hA0, 8'h01};
      repeat (16) @(posedge ref_clk);
      @(negedge ref_clk);
      sys_rst = 1'b0;
      check_bit(sda_oe, 1'b0);
      check_bit(sda_o, 1'b0);
      check_bit(write_busy, 1'b0);
      repeat (10) @(negedge ref_clk);
      foreach (rows[i]) begin
         set_pointer(rows[i].sel, rows[i].word);
         sesa_master_model_i.send_byte(rows[i].data, ack);
         check_bit(ack, 1'b1);
         sesa_master_model_i.stop_cond();
         wait_ready();
         read_at(rows[i].sel, rows[i].word);
         sesa_master_model_i.recv_byte(1'b0, rd);
         check_byte(rd, rows[i].data);
         sesa_master_model_i.stop_cond();
      end
      sesa_master_model_i.start_cond();
      sesa_master_model_i.send_byte(8'hB0, ack);
      check_bit(ack, 1'b0);
      sesa_master_model_i.send_byte(8'hA0, ack);
      check_bit(ack, 1'b0);
      sesa_master_model_i.stop_cond();
      read_at(3'h7, 8'hFF);
      sesa_master_model_i.recv_byte(1'b1, rd);
      check_byte(rd, 8'h5A);
      sesa_master_model_i.recv_byte(1'b0, rd);
      check_byte(rd, 8'hC3);
      sesa_master_model_i.stop_cond();
      set_pointer(3'h2, 8'h3E);
      for (int k = 0; k < 33; k++) begin
         sesa_master_model_i.send_byte(8'h40 + k[7:0], ack);
         check_bit(ack, 1'b1);
      end
      sesa_master_model_i.stop_cond();
      wait_ready();
      read_at(3'h2, 8'h20);
      for (int j = 0; j < 31; j++) begin
         sesa_master_model_i.recv_byte(j < 30, rd);
         check_byte(rd, page_exp(j));
      end
      sesa_master_model_i.stop_cond();
      dev_addr(3'h2, 1'b1, ack);
      check_bit(ack, 1'b1);
      sesa_master_model_i.recv_byte(1'b0, rd);
      check_byte(rd, page_exp(31));
      sesa_master_model_i.stop_cond();
      // A reset in the middle of a write cycle must clear busy and leave the bus usable.
      set_pointer(3'h1, 8'h10);
      sesa_master_model_i.send_byte(8'h77, ack);
      check_bit(ack, 1'b1);
      sesa_master_model_i.stop_cond();
      repeat (20) @(negedge ref_clk);
      check_bit(write_busy, 1'b1);
      sys_rst = 1'b1;
      repeat (16) @(negedge ref_clk);
      sys_rst = 1'b0;
      check_bit(sda_oe, 1'b0);
      check_bit(write_busy, 1'b0);
      dev_addr(3'h1, 1'b0, ack);
      check_bit(ack, 1'b1);
      sesa_master_model_i.stop_cond();
      end_of_test();
   end
endmodule

`default_nettype wire
